// File: core/ldcc_ctrl.sv
// lcd driver control command interpreter with host pins and avalon regs
`timescale 1ns/1ps

// How it works
// RL1 - rmw: writes advance column, reads hold it
// RL2 - rmw end restores column saved at entry
// RL3 - rmw command bit zero: 0 enter, 1 end
// RL4 - host avoids column set during rmw
// RL5 - reset instruction loads listed initial values
// RL6 - reset instruction leaves display ram untouched
// RL7 - host uses hardware reset pin at power-up
// RL8 - supply instruction bit zero switches supplies
// RL9 - booster runs only with oscillator running
// RL10 - external lcd supply means internal stays off
// RL11 - driver instruction bit zero gates waveforms
// RL12 - no waveform before driver-on instruction
// RL13 - static on with display off enters power-save
// RL14 - power-save stops clocks, outputs at supply
// RL15 - static off leaves power-save immediately
// RL16 - segment direction bit selects column order
// RL17 - contrast code maps to 201 levels
// RL18 - host should use contrast codes above 4fh
// RL19 - host enables supply before using contrast
// RL20 - select pin high parallel, low serial
// RL21 - serial mode has no reads
// RL22 - command/data select and direction decode access
// RL23 - serial msb first, eighth edge completes byte
// RL24 - chip deselect ignores bus, floats, clears serial

module ldcc_ctrl #(
  parameter int COLUMNS = 132 // segment columns addressed by the counter
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic chip_select_n_in,
  input wire logic command_data_select_in,
  input wire logic read_strobe_in, // rd_n, or enable in 68 style
  input wire logic write_strobe_in, // wr_n, or read/write in 68 style
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic parallel_select_in,
  input wire logic bus_style_select_in,
  input wire logic hardware_reset_pin_n_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic supply_run_out,
  output logic osc_run_out,
  output logic driver_active_out,
  output logic outputs_at_supply_out,
  output logic power_save_out,
  output logic segment_reverse_out,
  output logic [7:0] contrast_step_out,
  output logic [7:0] column_out
);

  // refused at elaboration: the counter is eight bits and must wrap
  if (COLUMNS < 2 || COLUMNS > 256) begin : g_bad_columns
    $error("COLUMNS must lie between 2 and 256");
  end

  localparam logic [7:0] COL_LAST = 8'(COLUMNS - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_n_p, rd_p, wr_p, scl_p; // previous filtered strobes
    logic [7:0] shift; // serial shift register
    logic [2:0] bit_cnt; // serial bit counter
    logic sub_mode; // sub instruction table selected
    logic [3:0] evr_hi, evr_lo; // staged contrast nibbles
    logic rmw; // read-modify-write active
    logic [7:0] rmw_col; // column saved at rmw entry
    logic [7:0] col; // column address counter
    logic [7:0] contrast; // contrast_level_register
    logic [3:0] bias;
    logic [2:0] boost;
    logic [6:0] start_line;
    logic [3:0] page;
    logic duty_full;
    logic [5:0] inverse;
    logic supply_on, drive_en, display_on, static_on, seg_rev;
    logic power_save, osc_run, supply_run, drive_act;
    logic [7:0] contrast_step;
    logic [7:0] holder; // bus holder of the last data byte
    logic [7:0] last_cmd;
    logic cmd_pend; // software instruction waiting
    logic [7:0] dq; // parallel read data
    logic dq_oe;
    logic av_wait;
    logic [31:0] av_rdata;
  } ldcc_st_t;

  ldcc_st_t st_r;
  ldcc_st_t st_nxt;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  logic [ldcc_pkg::PIN_W-1:0] pin_raw;
  logic [ldcc_pkg::PIN_W-1:0] pin;

  assign pin_raw = {data_in, hardware_reset_pin_n_in, bus_style_select_in,
                    parallel_select_in, serial_data_in, serial_clock_in,
                    write_strobe_in, read_strobe_in, command_data_select_in,
                    chip_select_n_in};

  ldcc_pin_sync #(
    .W(ldcc_pkg::PIN_W),
    .INIT(ldcc_pkg::PIN_IDLE)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .pin_in(pin_raw),
    .level_out(pin)
  );

  // decoded events, module level so assertions can watch them
  logic sel, par, rd_act, wr_evt, rd_evt, byte_v, byte_data;
  logic cmd_v, dwr_v, drd_v, av_req, av_cmd_acc;
  logic [7:0] byte_val, cmd;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    sel = !pin[ldcc_pkg::PIN_CS_N];
    par = pin[ldcc_pkg::PIN_PS]; // RL20
    byte_v = 1'b0;
    byte_val = pin[ldcc_pkg::PIN_D0 +: 8];
    byte_data = pin[ldcc_pkg::PIN_CDS];
    wr_evt = 1'b0;
    rd_evt = 1'b0;
    rd_act = 1'b0;
    st_nxt.cs_n_p = pin[ldcc_pkg::PIN_CS_N];
    st_nxt.rd_p = pin[ldcc_pkg::PIN_RD];
    st_nxt.wr_p = pin[ldcc_pkg::PIN_WR];
    st_nxt.scl_p = pin[ldcc_pkg::PIN_SCL];

    // parallel strobes: 80 style low-active, 68 style enable + direction
    if (pin[ldcc_pkg::PIN_BSS]) begin
      rd_act = pin[ldcc_pkg::PIN_RD] && pin[ldcc_pkg::PIN_WR];
      wr_evt = st_r.rd_p && !pin[ldcc_pkg::PIN_RD] && !st_r.wr_p;
      rd_evt = !st_r.rd_p && rd_act;
    end else begin
      rd_act = !pin[ldcc_pkg::PIN_RD];
      wr_evt = !st_r.wr_p && pin[ldcc_pkg::PIN_WR];
      rd_evt = st_r.rd_p && rd_act;
    end

    // RL24: deselected bus is ignored, serial state cleared, pins float
    if (!sel) begin
      st_nxt.shift = '0;
      st_nxt.bit_cnt = '0;
      rd_act = 1'b0;
      rd_evt = 1'b0;
      wr_evt = 1'b0;
    end else if (par) begin
      byte_v = wr_evt; // RL22
    end else if (!st_r.scl_p && pin[ldcc_pkg::PIN_SCL]) begin
      // RL23: msb first on rising serial clock
      st_nxt.shift = {st_r.shift[6:0], pin[ldcc_pkg::PIN_SI]};
      st_nxt.bit_cnt = st_r.bit_cnt + 3'd1;
      if (st_r.bit_cnt == ldcc_pkg::SER_LAST_BIT) begin
        byte_v = 1'b1; // RL23
        byte_val = st_nxt.shift;
      end
    end

    // RL21: reads exist only on the parallel bus
    rd_act = rd_act && par;
    rd_evt = rd_evt && par;
    st_nxt.dq_oe = rd_act;
    if (rd_evt) begin
      // RL22: status when command/data select low, else bus holder
      st_nxt.dq = byte_data ? st_r.holder :
                  {1'b0, st_r.seg_rev, st_r.display_on, st_r.power_save,
                   st_r.rmw, 3'h0};
    end

    // pin instruction bytes win; a software instruction waits for a cycle without one
    dwr_v = byte_v && byte_data;
    drd_v = rd_evt && byte_data;
    cmd_v = (byte_v && !byte_data) || st_r.cmd_pend;
    cmd = (byte_v && !byte_data) ? byte_val : st_r.last_cmd;
    if (!(byte_v && !byte_data)) begin
      st_nxt.cmd_pend = 1'b0;
    end else if (!st_r.cmd_pend) begin
      // a waiting software byte keeps its slot until it has run
      st_nxt.last_cmd = byte_val;
    end

    // RL1: column follows data accesses
    if (dwr_v) begin
      st_nxt.holder = byte_val;
      st_nxt.col = (st_r.col == COL_LAST) ? '0 : st_r.col + 8'd1;
    end else if (drd_v && !st_r.rmw) begin
      st_nxt.col = (st_r.col == COL_LAST) ? '0 : st_r.col + 8'd1;
    end

    // instruction decode
    if (cmd_v && st_r.sub_mode) begin
      if (cmd == ldcc_pkg::OP_SUB_END) begin
        st_nxt.sub_mode = 1'b0;
      end else if (cmd[7:4] == ldcc_pkg::OP_EVR_HI[7:4]) begin
        st_nxt.evr_hi = cmd[3:0];
      end else if (cmd[7:4] == ldcc_pkg::OP_EVR_LO[7:4]) begin
        st_nxt.evr_lo = cmd[3:0];
      end else if (cmd == ldcc_pkg::OP_EVR_EXEC) begin
        st_nxt.contrast = {st_r.evr_hi, st_r.evr_lo};
      end
    end else if (cmd_v) begin
      case (cmd[7:4])
        ldcc_pkg::OP_COL_LO[7:4]: begin
          // RL4: column set is not honoured while rmw is active
          if (!st_r.rmw) begin
            st_nxt.col = {st_r.col[7:4], cmd[3:0]};
          end
        end
        ldcc_pkg::OP_COL_HI[7:4]: begin
          if (!st_r.rmw) begin
            st_nxt.col = {cmd[3:0], st_r.col[3:0]};
          end
        end
        ldcc_pkg::OP_SUPPLY[7:4]: begin
          if (cmd[7:1] == ldcc_pkg::OP_SUPPLY[7:1]) begin
            st_nxt.supply_on = cmd[0]; // RL8
          end else if (cmd[7:1] == ldcc_pkg::OP_DRIVER[7:1]) begin
            st_nxt.drive_en = cmd[0]; // RL11
          end
        end
        ldcc_pkg::OP_BOOST[7:4]: begin
          if (!cmd[3]) begin
            st_nxt.boost = cmd[2:0];
          end
        end
        ldcc_pkg::OP_SUB_ENTER[7:4]: begin
          if (cmd == ldcc_pkg::OP_SUB_ENTER) begin
            st_nxt.sub_mode = 1'b1;
          end
        end
        ldcc_pkg::OP_ADC[7:4]: begin
          if (cmd[7:1] == ldcc_pkg::OP_ADC[7:1]) begin
            st_nxt.seg_rev = cmd[0]; // RL16
          end else if (cmd[7:1] == ldcc_pkg::OP_STATIC[7:1]) begin
            st_nxt.static_on = cmd[0]; // RL13 RL15
          end else if (cmd[7:1] == ldcc_pkg::OP_DISPLAY[7:1]) begin
            st_nxt.display_on = cmd[0]; // RL13
          end
        end
        ldcc_pkg::OP_BIAS[7:4]: begin
          st_nxt.bias = cmd[3:0];
        end
        ldcc_pkg::OP_RMW[7:4]: begin
          if (cmd[7:1] == ldcc_pkg::OP_RMW[7:1]) begin
            if (!cmd[0] && !st_r.rmw) begin
              st_nxt.rmw = 1'b1; // RL3
              st_nxt.rmw_col = st_r.col;
            end else if (cmd[0] && st_r.rmw) begin
              st_nxt.rmw = 1'b0; // RL3
              st_nxt.col = st_r.rmw_col; // RL2
            end
          end else if (cmd == ldcc_pkg::OP_RESET) begin
            // RL5: initial values; holder and ram side untouched (RL6)
            st_nxt.col = ldcc_pkg::RST_COLUMN;
            st_nxt.start_line = ldcc_pkg::RST_START;
            st_nxt.page = ldcc_pkg::RST_PAGE;
            st_nxt.contrast = ldcc_pkg::RST_CONTRAST;
            st_nxt.duty_full = ldcc_pkg::RST_DUTY_FULL;
            st_nxt.bias = ldcc_pkg::RST_BIAS;
            st_nxt.boost = ldcc_pkg::RST_BOOST;
            st_nxt.inverse = ldcc_pkg::RST_INVERSE;
          end
        end
        default: begin
          st_nxt.last_cmd = st_nxt.last_cmd; // unknown codes do nothing
        end
      endcase
    end

    // avalon slave: wait drops one cycle after the request is seen
    av_req = avs_read_in || avs_write_in;
    av_cmd_acc = 1'b0;
    if (av_req && st_r.av_wait && !st_r.cmd_pend) begin
      st_nxt.av_wait = 1'b0;
      case (avs_address_in)
        ldcc_pkg::OFS_STATE: st_nxt.av_rdata = {23'h00_0000, !par,
          st_r.sub_mode, st_r.rmw, st_r.static_on, st_r.display_on,
          st_r.seg_rev, st_r.power_save, st_r.drive_en, st_r.supply_on};
        ldcc_pkg::OFS_SETTINGS: st_nxt.av_rdata = {9'h000, st_r.boost,
          st_r.bias, st_r.col, st_r.contrast};
        ldcc_pkg::OFS_COMMAND: st_nxt.av_rdata = {24'h00_0000,
          st_r.last_cmd};
        ldcc_pkg::OFS_LAYOUT: st_nxt.av_rdata = {10'h000, st_r.inverse,
          3'h0, st_r.duty_full, st_r.page, 1'b0, st_r.start_line};
        default: st_nxt.av_rdata = '0;
      endcase
    end else if (!st_r.av_wait) begin
      st_nxt.av_wait = 1'b1;
      // the write lands at the edge where the master sees wait low
      av_cmd_acc = avs_write_in && avs_byteenable_in[0] &&
                   avs_address_in == ldcc_pkg::OFS_COMMAND;
      if (av_cmd_acc) begin
        st_nxt.cmd_pend = 1'b1;
        st_nxt.last_cmd = avs_writedata_in[7:0];
      end
    end

    // hardware reset pin restores every setting and mode
    if (!pin[ldcc_pkg::PIN_RES_N]) begin
      st_nxt.col = ldcc_pkg::RST_COLUMN;
      st_nxt.start_line = ldcc_pkg::RST_START;
      st_nxt.page = ldcc_pkg::RST_PAGE;
      st_nxt.contrast = ldcc_pkg::RST_CONTRAST;
      st_nxt.duty_full = ldcc_pkg::RST_DUTY_FULL;
      st_nxt.bias = ldcc_pkg::RST_BIAS;
      st_nxt.boost = ldcc_pkg::RST_BOOST;
      st_nxt.inverse = ldcc_pkg::RST_INVERSE;
      st_nxt.rmw = 1'b0;
      st_nxt.sub_mode = 1'b0;
      st_nxt.supply_on = 1'b0;
      st_nxt.drive_en = 1'b0;
      st_nxt.display_on = 1'b0;
      st_nxt.static_on = 1'b0;
      st_nxt.seg_rev = 1'b0;
    end

    // derived drive state; kept in flops so every output is registered
    st_nxt.power_save = st_nxt.static_on && !st_nxt.display_on; // RL13
    st_nxt.osc_run = !st_nxt.power_save; // RL14
    // booster is only allowed to run on a live clock
    st_nxt.supply_run = st_nxt.supply_on && st_nxt.osc_run; // RL8 RL9
    st_nxt.drive_act = st_nxt.drive_en && !st_nxt.power_save; // RL11 RL12
    // codes below the floor clamp to the lowest level
    st_nxt.contrast_step = (st_nxt.contrast < ldcc_pkg::EVR_FLOOR) ? '0 :
                           st_nxt.contrast - ldcc_pkg::EVR_FLOOR; // RL17
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '0;
      st_r.cs_n_p <= 1'b1;
      st_r.rd_p <= 1'b1;
      st_r.wr_p <= 1'b1;
      st_r.contrast <= ldcc_pkg::RST_CONTRAST;
      st_r.contrast_step <= ldcc_pkg::RST_CONTRAST - ldcc_pkg::EVR_FLOOR;
      st_r.bias <= ldcc_pkg::RST_BIAS;
      st_r.boost <= ldcc_pkg::RST_BOOST;
      st_r.duty_full <= ldcc_pkg::RST_DUTY_FULL;
      st_r.osc_run <= 1'b1;
      st_r.av_wait <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign data_out = st_r.dq;
  assign data_oe_out = st_r.dq_oe;
  assign avs_readdata_out = st_r.av_rdata;
  assign avs_waitrequest_out = st_r.av_wait;
  assign supply_run_out = st_r.supply_run;
  assign osc_run_out = st_r.osc_run;
  assign driver_active_out = st_r.drive_act;
  assign outputs_at_supply_out = st_r.power_save; // RL14
  assign power_save_out = st_r.power_save;
  assign segment_reverse_out = st_r.seg_rev;
  assign contrast_step_out = st_r.contrast_step;
  assign column_out = st_r.col;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_RMW_READ_HOLD: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL1
    st_r.rmw && drd_v && !cmd_v && pin[ldcc_pkg::PIN_RES_N]
    |=> st_r.col == $past(st_r.col))
    else $error("column moved on a read during rmw");
  AST_RMW_END_RESTORE: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL2
    cmd_v && !st_r.sub_mode && cmd == 8'hE1 && st_r.rmw && pin[8]
    |=> !st_r.rmw && st_r.col == $past(st_r.rmw_col))
    else $error("rmw end did not restore column");
  AST_RMW_ENTER: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL3
    cmd_v && !st_r.sub_mode && cmd == 8'hE0 && !st_r.rmw && pin[8]
    |=> st_r.rmw && st_r.rmw_col == $past(st_r.col))
    else $error("rmw entry failed");
  AST_RESET_VALUES: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL5
    cmd_v && !st_r.sub_mode && cmd == 8'hE2 && !dwr_v
    |=> st_r.contrast == 8'hFF && st_r.col == 8'h00 && st_r.bias == 4'h8
        && st_r.boost == 3'h4 && st_r.inverse == 6'h00)
    else $error("reset instruction values wrong");
  AST_SUPPLY_BIT: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL8
    cmd_v && !st_r.sub_mode && cmd[7:1] == 7'h10 && pin[8]
    |=> st_r.supply_on == $past(cmd[0]))
    else $error("supply bit not applied");
  AST_DRIVER_GATE: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL12
    driver_active_out |-> st_r.drive_en && !st_r.power_save)
    else $error("waveform active without driver on");
  AST_PSAVE_STOPS: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL14
    power_save_out |-> !osc_run_out && !supply_run_out && !driver_active_out)
    else $error("power save left circuits running");
  AST_PSAVE_RELEASE: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL15
    cmd_v && !st_r.sub_mode && cmd == 8'hA4 && pin[8] |=> !power_save_out)
    else $error("static off did not release power save");
  AST_DESELECT: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL24
    pin[0] |=> st_r.bit_cnt == 3'h0 && !data_oe_out)
    else $error("deselect did not clear serial or float bus");
  AST_SERIAL_NO_READ: assert property (@(posedge clk_sys_in) disable iff (rst_in) // RL21
    !pin[6] |=> !data_oe_out)
    else $error("bus driven in serial mode");
  AST_AV_ANSWER: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (avs_read_in || avs_write_in) && st_r.av_wait && !st_r.cmd_pend
    |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("avalon answer not one cycle");

endmodule

// File: core/ldcc_pin_sync.sv
// three-stage synchroniser with agreement filter for host pins
`timescale 1ns/1ps

module ldcc_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1; // first stage, read only by s2
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt; // accepted level
  } ldcc_sync_st_t;

  ldcc_sync_st_t st_r;
  ldcc_sync_st_t st_nxt;

  // ----------------------------------------------------------------
  // next state: a level counts once stages two and three agree
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // disagreeing bits keep the previous level (glitch rejection)
    st_nxt.filt = (st_r.s3 & ~(st_r.s2 ^ st_r.s3)) |
                  (st_r.filt & (st_r.s2 ^ st_r.s3));
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '{s1: INIT, s2: INIT, s3: INIT, filt: INIT};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.filt;

endmodule

// File: core/ldcc_pkg.sv
// constants shared by the lcd driver control command block
package ldcc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_STATE = 4'h0; // mode and supply flags, ro
  localparam logic [3:0] OFS_SETTINGS = 4'h4; // contrast, column, bias, ro
  localparam logic [3:0] OFS_COMMAND = 4'h8; // instruction injection, rw
  localparam logic [3:0] OFS_LAYOUT = 4'hC; // start line, page, duty, ro

  // ----------------------------------------------------------------
  // instruction codes (main table)
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_COL_LO = 8'h00; // upper nibble match
  localparam logic [7:0] OP_COL_HI = 8'h10; // upper nibble match
  localparam logic [7:0] OP_SUPPLY = 8'h20; // bit 0 selects off/on
  localparam logic [7:0] OP_DRIVER = 8'h22; // bit 0 selects off/on
  localparam logic [7:0] OP_BOOST = 8'h30; // low three bits are level
  localparam logic [7:0] OP_SUB_ENTER = 8'h70;
  localparam logic [7:0] OP_SUB_END = 8'h71;
  localparam logic [7:0] OP_ADC = 8'hA0; // bit 0 reverses segments
  localparam logic [7:0] OP_STATIC = 8'hA4; // bit 0 static drive on
  localparam logic [7:0] OP_DISPLAY = 8'hAE; // bit 0 display on
  localparam logic [7:0] OP_BIAS = 8'hB0; // low nibble is bias code
  localparam logic [7:0] OP_RMW = 8'hE0; // bit 0: 0 enter, 1 end
  localparam logic [7:0] OP_RESET = 8'hE2;

  // ----------------------------------------------------------------
  // instruction codes (sub table)
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_EVR_HI = 8'h80; // upper nibble match
  localparam logic [7:0] OP_EVR_LO = 8'h90; // upper nibble match
  localparam logic [7:0] OP_EVR_EXEC = 8'hA0;

  // ----------------------------------------------------------------
  // initial values loaded by the reset instruction
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_COLUMN = 8'h00;
  localparam logic [6:0] RST_START = 7'h00;
  localparam logic [3:0] RST_PAGE = 4'h0;
  localparam logic [7:0] RST_CONTRAST = 8'hFF;
  localparam logic [3:0] RST_BIAS = 4'h8; // 1/12 bias
  localparam logic [2:0] RST_BOOST = 3'h4; // six-times boost
  localparam logic [5:0] RST_INVERSE = 6'h00;
  localparam logic RST_DUTY_FULL = 1'b1; // 1/128 duty

  // ----------------------------------------------------------------
  // contrast scale and serial framing
  // ----------------------------------------------------------------
  localparam logic [7:0] EVR_FLOOR = 8'h37; // lowest of 201 levels
  localparam logic [2:0] SER_LAST_BIT = 3'h7; // eighth clock edge

  // ----------------------------------------------------------------
  // synchronised pin vector layout
  // ----------------------------------------------------------------
  localparam int PIN_CS_N = 0;
  localparam int PIN_CDS = 1;
  localparam int PIN_RD = 2;
  localparam int PIN_WR = 3;
  localparam int PIN_SCL = 4;
  localparam int PIN_SI = 5;
  localparam int PIN_PS = 6;
  localparam int PIN_BSS = 7;
  localparam int PIN_RES_N = 8;
  localparam int PIN_D0 = 9;
  localparam int PIN_W = 17;
  // idle pin levels: deselected, strobes high, reset pin asserted
  localparam logic [16:0] PIN_IDLE = 17'h0_000D;

endpackage

// File: sim/ldcc_host_model.sv
// host microprocessor model on the 80 style parallel pins and the serial pins
`timescale 1ns/1ps
module ldcc_host_model (
  input wire logic clk_sys_in,
  output logic cs_n_out = 1'b1,
  output logic cds_out = 1'b0,
  output logic rd_n_out = 1'b1,
  output logic wr_n_out = 1'b1,
  output logic res_n_out = 1'b0,
  output logic [7:0] data_out = 8'h00,
  output logic ps_out = 1'b1,
  output logic scl_out = 1'b0,
  output logic si_out = 1'b0
);
  // serial byte msb first; read strobe held low to show reads refused
  task ser(input logic cds, input logic [7:0] d);
    @(posedge clk_sys_in);
    ps_out <= 1'b0;
    cs_n_out <= 1'b0;
    rd_n_out <= 1'b0;
    cds_out <= cds;
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(posedge clk_sys_in);
      si_out <= d[i];
      scl_out <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      scl_out <= 1'b1;
    end
    repeat (4) @(posedge clk_sys_in);
    scl_out <= 1'b0;
    cs_n_out <= 1'b1;
    rd_n_out <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    ps_out <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
  endtask
  // one bus cycle; each strobe phase lasts 4 clocks to pass the filter
  task put(input logic sel, input logic rd, input logic cds,
    input logic [7:0] d);
    @(posedge clk_sys_in);
    cs_n_out <= !sel;
    cds_out <= cds;
    data_out <= d;
    repeat (4) @(posedge clk_sys_in);
    if (rd)
      rd_n_out <= 1'b0;
    else
      wr_n_out <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    rd_n_out <= 1'b1;
    wr_n_out <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    cs_n_out <= 1'b1;
    // a released bus must not keep showing the last byte
    data_out <= ~d;
    repeat (8) @(posedge clk_sys_in);
  endtask
  // power-up goes through the reset pin, not the instruction
  task hw_reset;
    @(posedge clk_sys_in);
    res_n_out <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    res_n_out <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
  endtask
endmodule

// File: sim/testbench.sv
// self-checking bench for the lcd driver control command block
`timescale 1ns/1ps
module testbench;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdat, got, q;
  logic cs_n, cds, rd_n, wr_n, res_n, wreq, sup, osc, drv, vdd, ps, rev;
  logic oe, par_sel, scl, sdi;
  logic [7:0] pd, c, step, col, dq;
  logic [31:0] exp_q[$];
  int errors = 0;
  int compares = 0;
  event seen;
  // 250 MHz system clock
  always #2 clk_sys_in = ~clk_sys_in;
  ldcc_host_model h_u (.clk_sys_in(clk_sys_in), .cs_n_out(cs_n),
    .cds_out(cds), .rd_n_out(rd_n), .wr_n_out(wr_n), .res_n_out(res_n),
    .data_out(pd), .ps_out(par_sel), .scl_out(scl), .si_out(sdi));
  ldcc_ctrl dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .chip_select_n_in(cs_n), .command_data_select_in(cds),
    .read_strobe_in(rd_n), .write_strobe_in(wr_n), .serial_clock_in(scl),
    .serial_data_in(sdi), .parallel_select_in(par_sel),
    .bus_style_select_in(1'b0), .hardware_reset_pin_n_in(res_n),
    .data_in(pd), .data_out(dq), .data_oe_out(oe), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .supply_run_out(sup), .osc_run_out(osc),
    .driver_active_out(drv), .outputs_at_supply_out(vdd),
    .power_save_out(ps), .segment_reverse_out(rev),
    .contrast_step_out(step), .column_out(col));
  // note the expectation, hand the observed value to the monitor
  task chk(input logic [31:0] e, input logic [31:0] a);
    @(negedge clk_sys_in);
    exp_q.push_back(e);
    got = a;
    -> seen;
  endtask
  // monitor takes the oldest note for each result
  always @(seen) begin
    compares++;
    if (got !== exp_q[0]) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp_q[0]);
    end
    void'(exp_q.pop_front());
  end
  // avalon access held until waitrequest is sampled low
  task av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    @(posedge clk_sys_in iff wreq === 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watchdog, far beyond the expected run of a few microseconds
  initial begin
    #40000;
    errors++;
    test_done;
  end
  initial begin
    q = $urandom(72251);
    c = 8'h50 + 8'($urandom % 176);
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    h_u.hw_reset();
    chk(drv, 0);
    h_u.put(1, 0, 0, 8'h21);
    chk(sup, 1);
    h_u.put(1, 0, 0, 8'h23);
    chk(drv, 1);
    h_u.put(0, 0, 0, 8'h22);
    chk(drv, 1);
    h_u.put(1, 0, 0, 8'hAF);
    h_u.put(1, 0, 0, 8'hA5);
    chk(ps, 0);
    h_u.put(1, 0, 0, 8'hAE);
    chk({ps, vdd, osc, sup, drv}, 5'h18);
    h_u.put(1, 0, 0, 8'hA4);
    chk({ps, osc, drv}, 3'h3);
    for (int i = 1; i >= 0; i--) begin
      h_u.put(1, 0, 0, {7'h50, i[0]});
      chk(rev, i[0]);
    end
    $display("power and segment test done");
    h_u.put(1, 0, 0, 8'h70);
    h_u.put(1, 0, 0, {4'h8, c[7:4]});
    h_u.put(1, 0, 0, {4'h9, c[3:0]});
    h_u.put(1, 0, 0, 8'hA0);
    h_u.put(1, 0, 0, 8'h71);
    chk(step, c - 8'h37);
    h_u.put(1, 0, 0, 8'h10);
    h_u.put(1, 0, 0, {4'h0, c[3:0]});
    h_u.put(1, 0, 0, 8'hE0);
    h_u.put(1, 0, 1, c);
    chk(col, c[3:0] + 1);
    h_u.put(1, 1, 1, 8'h00);
    chk({oe, dq}, {1'b0, c});
    h_u.put(1, 1, 0, 8'h00);
    chk(dq, 8'h08);
    chk(col, c[3:0] + 1);
    h_u.put(1, 0, 0, 8'hE1);
    chk(col, c[3:0]);
    $display("contrast and rmw test done");
    av(1, 4'h8, 32'h0000_00E2);
    repeat (4) @(posedge clk_sys_in);
    av(0, 4'h4, 32'h0000_0000);
    chk(q, 32'h0048_00FF);
    av(0, 4'hC, 32'h0000_0000);
    chk(q, 32'h0000_1000);
    av(0, 4'h2, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    $display("register test done");
    h_u.ser(0, 8'h22);
    chk({drv, oe, dq}, {2'b00, 8'h08});
    h_u.ser(1, c);
    chk(col, 1);
    $display("serial test done");
    test_done;
  end
endmodule
